/* nbt_target.sv */
// Notes on behaviour
// R1: Frame low with 1101b starts a read.
// R2: Frame low with 1110b starts a write.
// R3: Select nibble compared against strap pins.
// R4: Seven address nibbles, most significant first.
// R5: Read size codes 0, 2, 4, 7 accepted.
// R6: Burst start address has low bits cleared.
// R7: Host turnaround, then target owns the lines.
// R8: Target drives two wait-sync nibbles 0101b.
// R9: One ready-sync 0000b before read data.
// R10: Read byte sent low nibble first.
// R11: Burst repeats data phase per byte.
// R12: Read ends with 1111b, then release.
// R13: Write size must be 0000b, one byte.
// R14: Write byte taken low nibble first.
// R15: Write acknowledged by sync 0000b.
// R16: Write ends with 1111b, then release.
// R17: Frame low mid-cycle aborts, lines released.
// R18: Idle with frame high keeps lines released.
// R19: Either reset input low deselects the target.
// R20: Mismatched select never drives the lines.
`timescale 1ns/100ps
`default_nettype none
module nbt_target #(
  parameter int ADDR_W = 28
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              interface_reset_n,
  input  wire logic              cpu_reset_n,
  input  wire logic              frame_n,
  input  wire logic [3:0]        nibble_io_lines_in,
  output logic      [3:0]        nibble_io_lines_out,
  output logic                   nibble_io_lines_oe,
  input  wire logic [3:0]        strap_id_pins,
  output logic      [ADDR_W-1:0] rd_addr,
  input  wire logic [7:0]        rd_data,
  output logic                   rd_take,
  output logic                   wr_strobe,
  output logic      [ADDR_W-1:0] wr_addr,
  output logic      [7:0]        wr_data
);

  // Elaboration check on the address width
  if (ADDR_W < 8 || ADDR_W > nbt_pkg::DOC_ADDR_W)
  begin : g_bad_width
    $error("nbt_target: ADDR_W must lie between 8 and 28");
  end

  // Index of the last byte of a burst for a size code
  function automatic logic [6:0] burst_last(input logic [3:0] sz);
    logic [7:0] span;
    span = 8'h01 << sz[2:0];
    return 7'(span - 8'h01);
  endfunction

  // Clears the low address bits that a burst ignores
  function automatic logic [ADDR_W-1:0] align_addr(
    input logic [ADDR_W-1:0] a,
    input logic [3:0]        sz);
    logic [ADDR_W-1:0] mask;
    mask = ADDR_W'(burst_last(sz));
    return a & ~mask;
  endfunction

  nbt_pkg::nbt_state_t state_reg;   // Current bus cycle phase
  nbt_pkg::nbt_state_t state_next;  // Phase for the next cycle
  logic [6:0]          cnt_reg;     // Nibble, wait or byte counter
  logic [6:0]          cnt_next;    // Next counter value
  logic                is_rd_reg;   // Transaction is a read
  logic [3:0]          size_reg;    // Size code of the read
  logic [ADDR_W-1:0]   rd_addr_reg; // Address of the byte being read
  logic [7:0]          byte_reg;    // Byte being sent
  logic                rd_take_reg; // Byte taken from memory
  logic                wr_stb_reg;  // Write byte complete
  logic [3:0]          out_reg;     // Nibble driven on the lines
  logic                oe_reg;      // Lines driven
  logic [7:0]          seen_reg;    // Bytes sent, for checking

  nbt_field_if #(.ADDR_W(ADDR_W)) fld ();

  // Address and write byte collector
  nbt_collect #(.ADDR_W(ADDR_W)) u_collect (
    .mclk  (mclk),
    .rst_n (rst_n),
    .fld   (fld)
  );

  // Decoding of the line state
  wire       ifc_ok   = interface_reset_n & cpu_reset_n;      // see R19
  wire       frame_ok = frame_n & ifc_ok;
  wire [3:0] nib      = nibble_io_lines_in;
  wire       start_rd = !frame_n && nib == nbt_pkg::NIB_START_RD;  // see R1
  wire       start_wr = !frame_n && nib == nbt_pkg::NIB_START_WR;  // see R2
  wire       sel_ok   = nib == strap_id_pins;                 // see R3
  wire       size_rok = nib == nbt_pkg::SZ_1  || nib == nbt_pkg::SZ_4 ||
                        nib == nbt_pkg::SZ_16 || nib == nbt_pkg::SZ_128;
  wire       drive_nx = state_next == nbt_pkg::ST_WAIT_SYNC_PHASE ||
                        state_next == nbt_pkg::ST_READY_SYNC_PHASE ||
                        state_next == nbt_pkg::ST_RDLO  ||
                        state_next == nbt_pkg::ST_RDHI  ||
                        state_next == nbt_pkg::ST_ACK   ||
                        state_next == nbt_pkg::ST_ETAR;
  wire [3:0] out_next =
    (state_next == nbt_pkg::ST_WAIT_SYNC_PHASE) ? nbt_pkg::NIB_WAIT_SYNC_PHASE :   // see R8
    (state_next == nbt_pkg::ST_READY_SYNC_PHASE) ? nbt_pkg::NIB_READY_SYNC_PHASE :   // see R9
    (state_next == nbt_pkg::ST_RDLO)  ? rd_data[3:0] :         // see R10
    (state_next == nbt_pkg::ST_RDHI)  ? byte_reg[7:4] :        // see R10
    (state_next == nbt_pkg::ST_ACK)   ? nbt_pkg::NIB_ACK :     // see R15
    nbt_pkg::NIB_TAR;                                          // see R12

  // Collector strobes
  assign fld.nibble     = nib;
  assign fld.shift_addr = frame_ok && state_reg == nbt_pkg::ST_ADDR;
  assign fld.take_lo    = frame_ok && state_reg == nbt_pkg::ST_WDLO;
  assign fld.take_hi    = frame_ok && state_reg == nbt_pkg::ST_WDHI;

  // Phase sequencer
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (!ifc_ok)
      state_next = nbt_pkg::ST_IDLE;  // see R19
    else if (!frame_n)
      // Any frame low restarts decoding, aborting a cycle in flight
      state_next = (start_rd || start_wr) ? nbt_pkg::ST_SEL
                                          : nbt_pkg::ST_IDLE;  // see R17
    else
      case (state_reg)
        nbt_pkg::ST_IDLE:
          state_next = nbt_pkg::ST_IDLE;  // see R18
        nbt_pkg::ST_SEL:
        begin
          // Another target is addressed: stay quiet until next start
          state_next = sel_ok ? nbt_pkg::ST_ADDR
                              : nbt_pkg::ST_IDLE;  // see R20
          cnt_next   = nbt_pkg::CNT_ZERO;
        end
        nbt_pkg::ST_ADDR:
        begin
          cnt_next = cnt_reg + nbt_pkg::CNT_ONE;
          if (cnt_reg == nbt_pkg::ADDR_LAST)
            state_next = nbt_pkg::ST_SIZE;  // see R4
        end
        nbt_pkg::ST_SIZE:
          if (is_rd_reg)
            state_next = size_rok ? nbt_pkg::ST_HTAR
                                  : nbt_pkg::ST_IDLE;  // see R5
          else
            state_next = (nib == nbt_pkg::SZ_1) ? nbt_pkg::ST_WDLO
                                                : nbt_pkg::ST_IDLE;  // see R13
        nbt_pkg::ST_WDLO:
          state_next = nbt_pkg::ST_WDHI;
        nbt_pkg::ST_WDHI:
          state_next = nbt_pkg::ST_HTAR;
        nbt_pkg::ST_HTAR:
          state_next = nbt_pkg::ST_DTAR;  // see R7
        nbt_pkg::ST_DTAR:
        begin
          state_next = is_rd_reg ? nbt_pkg::ST_WAIT_SYNC_PHASE
                                 : nbt_pkg::ST_ACK;  // see R7
          cnt_next   = nbt_pkg::CNT_ZERO;
        end
        nbt_pkg::ST_WAIT_SYNC_PHASE:
        begin
          cnt_next = cnt_reg + nbt_pkg::CNT_ONE;
          if (cnt_reg == nbt_pkg::WAIT_LAST)
            state_next = nbt_pkg::ST_READY_SYNC_PHASE;  // see R8
        end
        nbt_pkg::ST_READY_SYNC_PHASE:
        begin
          state_next = nbt_pkg::ST_RDLO;  // see R9
          cnt_next   = burst_last(size_reg);  // see R11
        end
        nbt_pkg::ST_RDLO:
          state_next = nbt_pkg::ST_RDHI;
        nbt_pkg::ST_RDHI:
          if (cnt_reg == nbt_pkg::CNT_ZERO)
            state_next = nbt_pkg::ST_ETAR;  // see R12
          else
          begin
            state_next = nbt_pkg::ST_RDLO;  // see R11
            cnt_next   = cnt_reg - nbt_pkg::CNT_ONE;
          end
        nbt_pkg::ST_ACK:
          state_next = nbt_pkg::ST_ETAR;  // see R16
        nbt_pkg::ST_ETAR:
          state_next = nbt_pkg::ST_IDLE;  // see R12 R16
        default:
          state_next = nbt_pkg::ST_IDLE;
      endcase
  end

  // Phase and counter registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= nbt_pkg::ST_IDLE;
      cnt_reg   <= nbt_pkg::CNT_ZERO;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Cycle type and read size
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      is_rd_reg <= 1'b0;
      size_reg  <= nbt_pkg::SZ_1;
    end
    else
    begin
      if (ifc_ok && (start_rd || start_wr))
        is_rd_reg <= start_rd;  // see R1 R2
      if (frame_ok && state_reg == nbt_pkg::ST_SIZE)
        size_reg <= nib;  // see R5
    end
  end

  // Read address: aligned at the size nibble, stepped per byte
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rd_addr_reg <= '0;
    else if (frame_ok && state_reg == nbt_pkg::ST_SIZE && is_rd_reg)
      rd_addr_reg <= align_addr(fld.addr, nib);  // see R6
    else if (frame_ok && state_reg == nbt_pkg::ST_RDLO)
      rd_addr_reg <= rd_addr_reg + ADDR_W'(1);  // see R11
  end

  // Byte capture and the two strobes
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byte_reg    <= '0;
      rd_take_reg <= 1'b0;
      wr_stb_reg  <= 1'b0;
    end
    else
    begin
      if (state_next == nbt_pkg::ST_RDLO)
        byte_reg <= rd_data;  // see R10
      rd_take_reg <= state_next == nbt_pkg::ST_RDLO;
      wr_stb_reg  <= frame_ok && state_reg == nbt_pkg::ST_WDHI;  // see R14
    end
  end

  // Line drive registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_reg <= nbt_pkg::NIB_TAR;
      oe_reg  <= 1'b0;
    end
    else
    begin
      out_reg <= out_next;
      oe_reg  <= drive_nx;
    end
  end

  // Byte count kept only for the burst check
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      seen_reg <= '0;
    else if (state_reg == nbt_pkg::ST_READY_SYNC_PHASE)
      seen_reg <= '0;
    else if (state_reg == nbt_pkg::ST_RDLO)
      seen_reg <= seen_reg + 8'h01;
  end

  // Release at once on frame low or either reset input
  assign nibble_io_lines_oe  = oe_reg & frame_ok;  // see R17 R19
  assign nibble_io_lines_out = out_reg;
  assign rd_addr             = rd_addr_reg;
  assign rd_take             = rd_take_reg;
  assign wr_strobe           = wr_stb_reg;
  assign wr_addr             = fld.addr;
  assign wr_data             = fld.wdata;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_read_start;
    state_reg == nbt_pkg::ST_IDLE && ifc_ok && start_rd;
  endsequence
  sequence s_sel_hit;
    state_reg == nbt_pkg::ST_SEL && frame_ok && sel_ok;
  endsequence
  sequence s_addr_run;
    (frame_ok)[*7];
  endsequence

  a_read_start: assert property (  // see R1
    s_read_start |=> state_reg == nbt_pkg::ST_SEL && is_rd_reg)
    else $error("read start not taken");
  a_write_start: assert property (  // see R2
    state_reg == nbt_pkg::ST_IDLE && ifc_ok && start_wr
    |=> state_reg == nbt_pkg::ST_SEL && !is_rd_reg)
    else $error("write start not taken");
  a_addr_seven: assert property (  // see R4
    s_sel_hit ##1 s_addr_run |=> state_reg == nbt_pkg::ST_SIZE)
    else $error("address phase not seven cycles");
  a_sel_miss: assert property (  // see R20
    state_reg == nbt_pkg::ST_SEL && frame_ok && !sel_ok
    |=> state_reg == nbt_pkg::ST_IDLE && !oe_reg)
    else $error("unselected target went on");
  a_burst_align: assert property (  // see R6
    frame_ok && state_reg == nbt_pkg::ST_SIZE && is_rd_reg && size_rok
    |=> (rd_addr_reg & ADDR_W'(burst_last(size_reg))) == '0)
    else $error("burst start address not aligned");
  a_wait_pair: assert property (  // see R8
    frame_ok && state_reg == nbt_pkg::ST_DTAR && is_rd_reg ##1 frame_ok
    |-> out_reg == nbt_pkg::NIB_WAIT_SYNC_PHASE && oe_reg
        ##1 out_reg == nbt_pkg::NIB_WAIT_SYNC_PHASE && oe_reg)
    else $error("wait-sync pair wrong");
  a_ready_sync: assert property (  // see R9
    frame_ok && state_reg == nbt_pkg::ST_WAIT_SYNC_PHASE && cnt_reg == nbt_pkg::WAIT_LAST
    |=> out_reg == nbt_pkg::NIB_READY_SYNC_PHASE && oe_reg)
    else $error("ready-sync missing");
  a_data_high: assert property (  // see R10
    frame_ok && state_reg == nbt_pkg::ST_RDLO
    |=> out_reg == $past(byte_reg[7:4]) && $past(out_reg) == byte_reg[3:0])
    else $error("read nibble order wrong");
  a_burst_len: assert property (  // see R11
    state_reg == nbt_pkg::ST_ETAR && is_rd_reg
    |-> seen_reg == 8'(8'h01 << size_reg[2:0]))
    else $error("burst length wrong");
  a_end_release: assert property (  // see R12 R16
    state_reg == nbt_pkg::ST_ETAR
    |-> out_reg == nbt_pkg::NIB_TAR && oe_reg ##1 !oe_reg)
    else $error("end turnaround or release wrong");
  a_write_ack: assert property (  // see R15
    frame_ok && state_reg == nbt_pkg::ST_DTAR && !is_rd_reg
    |=> out_reg == nbt_pkg::NIB_ACK && oe_reg)
    else $error("write sync missing");
  a_write_byte: assert property (  // see R14
    frame_ok && state_reg == nbt_pkg::ST_WDHI
    |=> wr_strobe && wr_data == {$past(nib), $past(nib, 2)})
    else $error("write byte wrong");
  a_abort_quiet: assert property (  // see R17 R19
    (!frame_n || !ifc_ok) |-> !nibble_io_lines_oe ##1 !oe_reg)
    else $error("lines driven after abort or reset");
  a_idle_quiet: assert property (  // see R18
    state_reg == nbt_pkg::ST_IDLE |-> !oe_reg)
    else $error("lines driven in standby");

endmodule
`default_nettype wire

/* nbt_pkg.sv */
`default_nettype none
package nbt_pkg;

  // Start nibbles that open a cycle
  localparam logic [3:0] NIB_START_RD = 4'hD;  // Read cycle
  localparam logic [3:0] NIB_START_WR = 4'hE;  // Single byte write cycle

  // Nibbles the target drives back
  localparam logic [3:0] NIB_TAR      = 4'hF;  // Turnaround
  localparam logic [3:0] NIB_WAIT_SYNC_PHASE    = 4'h5;  // Short wait-sync
  localparam logic [3:0] NIB_READY_SYNC_PHASE    = 4'h0;  // Ready-sync, data next
  localparam logic [3:0] NIB_ACK      = 4'h0;  // Write received

  // Transfer size codes
  localparam logic [3:0] SZ_1         = 4'h0;  // One byte
  localparam logic [3:0] SZ_4         = 4'h2;  // Four bytes
  localparam logic [3:0] SZ_16        = 4'h4;  // Sixteen bytes
  localparam logic [3:0] SZ_128       = 4'h7;  // 128 bytes

  // Phase counter values and widths
  localparam int         CNT_W        = 7;      // Counter width
  localparam int         DOC_ADDR_W   = 28;     // Address width on the bus
  localparam int         NIB_W        = 4;      // Bits per nibble
  localparam logic [6:0] CNT_ZERO     = 7'h00;  // Counter start
  localparam logic [6:0] CNT_ONE      = 7'h01;  // Counter step
  localparam logic [6:0] ADDR_LAST    = 7'h06;  // Seventh address nibble
  localparam logic [6:0] WAIT_LAST    = 7'h01;  // Second wait state

  // Protocol phases
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,  // Standby, lines released
    ST_SEL   = 4'h1,  // Chip select nibble
    ST_ADDR  = 4'h2,  // Seven address nibbles
    ST_SIZE  = 4'h3,  // Size nibble
    ST_WDLO  = 4'h4,  // Write data, low nibble
    ST_WDHI  = 4'h5,  // Write data, high nibble
    ST_HTAR  = 4'h6,  // Host turnaround
    ST_DTAR  = 4'h7,  // Target takes the lines, floating
    ST_WAIT_SYNC_PHASE = 4'h8,  // Wait-sync
    ST_READY_SYNC_PHASE = 4'h9,  // Ready-sync
    ST_RDLO  = 4'hA,  // Read data, low nibble
    ST_RDHI  = 4'hB,  // Read data, high nibble
    ST_ACK   = 4'hC,  // Write sync
    ST_ETAR  = 4'hD   // Target turnaround before release
  } nbt_state_t;

endpackage
`default_nettype wire

/* nbt_field_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface nbt_field_if #(parameter int ADDR_W = 28);
  logic [3:0]        nibble;      // Nibble seen on the lines
  logic              shift_addr;  // Shift one address nibble in
  logic              take_lo;     // Take the low write nibble
  logic              take_hi;     // Take the high write nibble
  logic [ADDR_W-1:0] addr;        // Assembled address
  logic [7:0]        wdata;       // Assembled write byte

  // Sequencer side
  modport ctrl (output nibble, output shift_addr, output take_lo,
                output take_hi, input addr, input wdata);
  // Collector side
  modport coll (input nibble, input shift_addr, input take_lo,
                input take_hi, output addr, output wdata);
endinterface
`default_nettype wire

/* nbt_collect.sv */
`timescale 1ns/100ps
`default_nettype none
module nbt_collect #(
  parameter int ADDR_W = 28
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  nbt_field_if.coll fld
);

  logic [ADDR_W-1:0] addr_reg;   // Address shift register
  logic [3:0]        wlo_reg;    // Low write nibble held
  logic [7:0]        wdata_reg;  // Complete write byte

  // Address arrives most significant nibble first
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      addr_reg <= '0;
    else if (fld.shift_addr)
      addr_reg <= {addr_reg[ADDR_W-nbt_pkg::NIB_W-1:0], fld.nibble};  // see R4
  end

  // Write byte arrives low nibble first
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wlo_reg   <= '0;
      wdata_reg <= '0;
    end
    else
    begin
      if (fld.take_lo)
        wlo_reg <= fld.nibble;  // see R14
      if (fld.take_hi)
        wdata_reg <= {fld.nibble, wlo_reg};  // see R14
    end
  end

  assign fld.addr  = addr_reg;
  assign fld.wdata = wdata_reg;

endmodule
`default_nettype wire

/* nbt_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Host chipset side: frames each cycle, then hands the lines over
module nbt_host_model (
  input  wire logic       mclk,
  input  wire logic [3:0] lines,
  input  wire logic       tgt_oe,
  input  wire logic       take,
  output logic            frame_n,
  output logic      [3:0] hst_out,
  output logic            hst_oe
);
  logic [5:0] cap [$];  // Sampled {take, oe, level} per cycle

  // Idle host: frame high, lines released
  initial
  begin
    frame_n = 1'b1;
    hst_out = 4'hF;
    hst_oe  = 1'b0;
  end

  // One host-driven cycle, launched at a rising edge
  task automatic drive(input logic [3:0] nib, input logic fr);
    @(posedge mclk);
    frame_n <= fr;
    hst_out <= nib;
    hst_oe  <= 1'b1;
  endtask

  // Start, select, address, size, data, turnaround, then release
  task automatic req(input logic wr, input logic [3:0] sel,
                     input logic [27:0] a, input logic [3:0] sz,
                     input logic [7:0] d);
    drive(wr ? nbt_pkg::NIB_START_WR : nbt_pkg::NIB_START_RD,
          1'b0);
    drive(sel, 1'b1);
    for (int i = 6; i >= 0; i--)
      drive(a[i*4 +: 4], 1'b1);
    drive(sz, 1'b1);
    if (wr)
    begin
      drive(d[3:0], 1'b1);
      drive(d[7:4], 1'b1);
    end
    drive(nbt_pkg::NIB_TAR, 1'b1);
    @(posedge mclk);
    hst_oe <= 1'b0;
  endtask

  // Sample the lines in mid-cycle for n cycles
  task automatic collect(input int n);
    cap.delete();
    repeat (n)
    begin
      @(negedge mclk);
      cap.push_back({take, tgt_oe, lines});
    end
  endtask
endmodule
`default_nettype wire

/* nbt_target_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module nbt_target_tb_top;
  localparam logic [3:0] STRAP = 4'h6;  // Our select value
  logic        mclk;               // Bus clock
  logic        rst_n;              // Async reset
  logic        interface_reset_n;  // Interface reset input
  logic        cpu_reset_n;        // CPU reset input
  logic        frame_n;            // Frame from host
  logic [3:0]  hst_out;            // Host nibble
  logic        hst_oe;             // Host drives lines
  logic [3:0]  last_lvl;           // Previous wire level
  logic [3:0]  t_out;              // Target nibble
  logic        t_oe;               // Target drives lines
  logic [27:0] rd_addr;            // Read address
  logic        rd_take;            // Byte taken
  logic        wr_strobe;          // Write done
  logic [27:0] wr_addr;            // Write address
  logic [7:0]  wr_data;            // Write byte
  logic [27:0] wa;                 // Last reported address
  logic [7:0]  wd;                 // Last reported byte
  int          wr_cnt;             // Writes reported
  int          error_cnt;          // Mismatches
  int          n_compared;         // Comparisons
  wire  logic [3:0] lines;         // Resolved wire level
  wire  logic [7:0] rd_data;       // Memory byte

  // Released wire shows a changing pattern, never a stale value
  assign lines = t_oe ? t_out : hst_oe ? hst_out : ~last_lvl;
  assign rd_data = mem(rd_addr);

  // Memory contents depend on low and high address bits
  function automatic logic [7:0] mem(input logic [27:0] a);
    return a[7:0] ^ {a[11:8], a[27:24]};
  endfunction

  // Clock, 5 ns period
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Remember the wire level for the float pattern
  always @(posedge mclk)
    last_lvl <= lines;

  nbt_target DUT (
    .mclk                (mclk),
    .rst_n               (rst_n),
    .interface_reset_n   (interface_reset_n),
    .cpu_reset_n         (cpu_reset_n),
    .frame_n             (frame_n),
    .nibble_io_lines_in  (lines),
    .nibble_io_lines_out (t_out),
    .nibble_io_lines_oe  (t_oe),
    .strap_id_pins       (STRAP),
    .rd_addr             (rd_addr),
    .rd_data             (rd_data),
    .rd_take             (rd_take),
    .wr_strobe           (wr_strobe),
    .wr_addr             (wr_addr),
    .wr_data             (wr_data)
  );

  nbt_host_model host (
    .mclk    (mclk),
    .lines   (lines),
    .tgt_oe  (t_oe),
    .take    (rd_take),
    .frame_n (frame_n),
    .hst_out (hst_out),
    .hst_oe  (hst_oe)
  );

  // Bus sample compare; a released sample compares take and oe only
  task automatic chk_bus(input logic [5:0] got, input logic [5:0] exp);
    n_compared++;
    if ((exp[4] ? got : {got[5:4], 4'h0}) !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: bus %b expected %b", $time, got, exp);
    end
  endtask

  // Value compare
  task automatic chk_val(input logic [27:0] got, input logic [27:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  // Watch write reports and the release rules every cycle
  always @(negedge mclk)
  begin
    if (wr_strobe === 1'b1)
    begin
      wr_cnt++;
      wa = wr_addr;
      wd = wr_data;
    end
    if (!(frame_n && interface_reset_n && cpu_reset_n && rst_n))
      chk_bus({1'b0, t_oe, 4'h0}, 6'h00);
  end

  // Read of any size: syncs, bytes from aligned address, end turnaround
  task automatic t_read(input logic [3:0] sz, input logic [27:0] a);
    int          n;
    logic [27:0] b;
    logic [7:0]  d;
    n = 1 << sz;
    b = a & ~((28'h1 << sz) - 28'h1);
    host.req(1'b0, STRAP, a, sz, 8'h00);
    host.collect(2 * n + 7);
    chk_bus(host.cap[0], 6'h00);
    chk_bus(host.cap[1], {2'b01, nbt_pkg::NIB_WAIT_SYNC_PHASE});
    chk_bus(host.cap[2], {2'b01, nbt_pkg::NIB_WAIT_SYNC_PHASE});
    chk_bus(host.cap[3], {2'b01, nbt_pkg::NIB_READY_SYNC_PHASE});
    for (int i = 0; i < n; i++)
    begin
      d = mem(b + 28'(i));
      chk_bus(host.cap[4 + 2 * i], {2'b11, d[3:0]});
      chk_bus(host.cap[5 + 2 * i], {2'b01, d[7:4]});
    end
    chk_bus(host.cap[2 * n + 4], {2'b01, nbt_pkg::NIB_TAR});
    chk_bus(host.cap[2 * n + 5], 6'h00);
    chk_bus(host.cap[2 * n + 6], 6'h00);
  endtask

  // Single byte write: sync, turnaround, release, byte reported
  task automatic t_write(input logic [27:0] a, input logic [7:0] d);
    int c;
    c = wr_cnt;
    host.req(1'b1, STRAP, a, nbt_pkg::SZ_1, d);
    host.collect(4);
    chk_bus(host.cap[0], 6'h00);
    chk_bus(host.cap[1], {2'b01, nbt_pkg::NIB_ACK});
    chk_bus(host.cap[2], {2'b01, nbt_pkg::NIB_TAR});
    chk_bus(host.cap[3], 6'h00);
    chk_val(28'(wr_cnt - c), 28'h1);
    chk_val(wa, a);
    chk_val({20'h0, wd}, {20'h0, d});
  endtask

  // Refused cycle: lines never driven, nothing reported
  task automatic t_quiet(input logic wr, input logic [3:0] sel,
                         input logic [3:0] sz);
    int c;
    c = wr_cnt;
    host.req(wr, sel, 28'h0123456, sz, 8'h3C);
    host.collect(20);
    foreach (host.cap[i])
      chk_bus(host.cap[i] & 6'h30, 6'h00);
    chk_val(28'(wr_cnt - c), 28'h0);
  endtask

  // Frame low in mid data abandons the burst and starts a new read
  task automatic t_abort;
    host.req(1'b0, STRAP, 28'h0000010, nbt_pkg::SZ_16, 8'h00);
    host.collect(6);
    t_read(nbt_pkg::SZ_1, 28'h00000A5);
  endtask

  // Interface reset releases the lines mid-burst; CPU reset blocks starts while low
  task automatic t_rst_in;
    host.req(1'b0, STRAP, 28'h0000040, nbt_pkg::SZ_16, 8'h00);
    host.collect(5);
    @(posedge mclk);
    interface_reset_n <= 1'b0;
    @(posedge mclk);
    interface_reset_n <= 1'b1;
    cpu_reset_n       <= 1'b0;
    t_quiet(1'b0, STRAP, nbt_pkg::SZ_1);
    @(posedge mclk);
    cpu_reset_n <= 1'b1;
    t_read(nbt_pkg::SZ_4, 28'h0BEEF01);
  endtask

  // Verdict and end of run
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    rst_n             = 1'b0;
    interface_reset_n = 1'b1;
    cpu_reset_n       = 1'b1;
    last_lvl          = 4'h0;
    wr_cnt            = 0;
    error_cnt         = 0;
    n_compared        = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_read(nbt_pkg::SZ_1, 28'hABCDE7F);
    t_read(nbt_pkg::SZ_4, 28'hABCDE7F);
    t_read(nbt_pkg::SZ_16, 28'hABCDE7F);
    t_read(nbt_pkg::SZ_128, 28'hABCDE7F);
    t_write(28'hFEDCBA9, 8'h5C);
    t_quiet(1'b0, ~STRAP, nbt_pkg::SZ_1);
    t_quiet(1'b1, STRAP ^ 4'h1, nbt_pkg::SZ_1);
    t_quiet(1'b0, STRAP, 4'h1);
    t_quiet(1'b1, STRAP, nbt_pkg::SZ_4);
    t_abort();
    t_rst_in();
    t_write(28'h0000003, 8'hA7);
    conclude();
  end

  // Watchdog well beyond the expected run of about 680 cycles
  initial
  begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end
endmodule
`default_nettype wire
